//--- ods_regs.svh
// Contract
// - each channel holds code 0..255; output is ref*code/256*(1+range_double).
// - range_double 0 gives unity span, 1 gives twice the reference span.
// - at power up every channel code is cleared to zero, outputs at ground.
// - with latch_strobe high, data is shifted in on each serial clock fall.
// - a low pulse on latch_strobe moves the shifted word to the selected channel.
// - with update_strobe low, the selected output updates on latch_strobe fall.
// - with update_strobe high, values are held until update_strobe pulses low.
// - the command word is shifted most significant bit first.
// - a word may arrive as two bursts of eight clocks while latch_strobe stays high.
// - channel_select 000 picks the first output up to 111 for the eighth.
// - code_bits 7 is most significant, 0 least; all zero drives ground.
// - the word is 12 bits: 8 code, 3 channel_select, 1 range_double.
// - channels are double buffered so all outputs can update together.
`ifndef ODS_REGS_SVH
`define ODS_REGS_SVH

`define ODS_NUM_CH 8
`define ODS_CODE_W 8
`define ODS_SEL_W 3
`define ODS_WORD_W 12
`define ODS_SEL_LSB 9
`define ODS_RANGE_BIT 8
`define ODS_CODE_LSB 0
`define ODS_BITCNT_W 5
`define ODS_BITCNT_MAX 5'h1F

`define ODS_ADDR_W 8
`define ODS_CTRL_OFS 8'h00
`define ODS_STATUS_OFS 8'h04
`define ODS_OUT_BASE 8'h20
`define ODS_HOLD_BASE 8'h40
`define ODS_CTRL_XFER_BIT 0
`define ODS_CTRL_CLEAR_BIT 1
`define ODS_STAT_WORD_LSB 0
`define ODS_STAT_BITS_LSB 16
`define ODS_STAT_LATCH_BIT 24
`define ODS_STAT_UPD_BIT 25
`define ODS_CH_RANGE_BIT 8

`define ODS_CODE_RST 8'h00
`define ODS_RANGE_RST 1'b0

`endif

//--- ods_pkg.sv
package ods_pkg;
  typedef logic [7:0] ods_code_t;
  typedef logic [11:0] ods_word_t;
  typedef logic [2:0] ods_sel_t;
  typedef enum logic [0:0] {ODS_BUS_IDLE, ODS_BUS_ACK} ods_bus_t;
endpackage

//--- ods_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ods_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // ods_sync
`default_nettype wire

//--- ods_shift.sv
`timescale 1ns/1ps
`default_nettype none
`include "ods_regs.svh"
module ods_shift (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk_s,
  input wire logic data_s,
  input wire logic latch_s,
  output ods_pkg::ods_word_t word_q,
  output logic [`ODS_BITCNT_W-1:0] bits_q,
  output logic take
);
  logic sclk_prev_q;
  logic latch_prev_q;
  logic sclk_fall;

  assign sclk_fall = sclk_prev_q & ~sclk_s;
  assign take = latch_prev_q & ~latch_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b0;
      latch_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      latch_prev_q <= latch_s;
    end
  end

  // no bit framing: extra bits simply fall off the top, so split bursts work
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= '0;
    end else if (sclk_fall && latch_s) begin
      word_q <= {word_q[`ODS_WORD_W-2:0], data_s};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bits_q <= '0;
    end else if (take) begin
      bits_q <= '0;
    end else if (sclk_fall && latch_s && bits_q != `ODS_BITCNT_MAX) begin
      bits_q <= bits_q + 1'b1;
    end
  end

  property p_shift_in;
    @(posedge clk) disable iff (!rst_b)
      (sclk_fall && latch_s) |=> (word_q == {$past(word_q[10:0]), $past(data_s)});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("serial bit not shifted in msb first");

  property p_shift_idle;
    @(posedge clk) disable iff (!rst_b)
      (!sclk_fall || !latch_s) |=> $stable(word_q);
  endproperty
  a_shift_idle: assert property (p_shift_idle) else $error("shift register moved without a gated clock fall");
endmodule // ods_shift
`default_nettype wire

//--- ods_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ods_regs.svh"
module ods_top #(
  parameter int NUM_CH = `ODS_NUM_CH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe,
  input wire logic update_strobe,
  input wire logic [`ODS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NUM_CH*`ODS_CODE_W-1:0] chan_code,
  output logic [NUM_CH-1:0] chan_range
);
  // pin synchronisers
  logic [3:0] pins_s;
  logic sclk_s;
  logic data_s;
  logic latch_s;
  logic upd_s;

  ods_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({serial_clk, serial_data, latch_strobe, update_strobe}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[3];
  assign data_s = pins_s[2];
  assign latch_s = pins_s[1];
  assign upd_s = pins_s[0];

  // serial shifter
  ods_pkg::ods_word_t word;
  logic [`ODS_BITCNT_W-1:0] bits;
  logic take;

  ods_shift u_shift (
    .clk(clk),
    .rst_b(rst_b),
    .sclk_s(sclk_s),
    .data_s(data_s),
    .latch_s(latch_s),
    .word_q(word),
    .bits_q(bits),
    .take(take)
  );

  // field split of the command word
  ods_pkg::ods_sel_t word_sel;
  ods_pkg::ods_code_t word_code;
  logic word_range;

  assign word_sel = word[`ODS_SEL_LSB +: `ODS_SEL_W];
  assign word_range = word[`ODS_RANGE_BIT];
  assign word_code = word[`ODS_CODE_LSB +: `ODS_CODE_W];

  // update strobe edge
  logic upd_prev_q;
  logic upd_fall;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upd_prev_q <= 1'b0;
    end else begin
      upd_prev_q <= upd_s;
    end
  end

  assign upd_fall = upd_prev_q & ~upd_s;

  // register bus
  ods_pkg::ods_bus_t bus_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_go;
  logic soft_xfer;
  logic soft_clear;
  logic is_ctrl;
  logic is_status;
  logic is_out;
  logic is_hold;
  logic [`ODS_SEL_W-1:0] reg_ch;

  assign req = (avs_read | avs_write) && bus_q == ods_pkg::ODS_BUS_IDLE;
  assign wr_go = avs_write && bus_q == ods_pkg::ODS_BUS_ACK;
  assign is_ctrl = avs_address == `ODS_CTRL_OFS;
  assign is_status = avs_address == `ODS_STATUS_OFS;
  assign is_out = avs_address[7:5] == `ODS_OUT_BASE >> 5 && avs_address[1:0] == 2'h0;
  assign is_hold = avs_address[7:5] == `ODS_HOLD_BASE >> 5 && avs_address[1:0] == 2'h0;
  assign reg_ch = avs_address[4:2];
  assign soft_xfer = wr_go && is_ctrl && avs_byteenable[0] && avs_writedata[`ODS_CTRL_XFER_BIT];
  assign soft_clear = wr_go && is_ctrl && avs_byteenable[0] && avs_writedata[`ODS_CTRL_CLEAR_BIT];

  // double buffered channel storage
  logic [`ODS_CODE_W-1:0] hold_code_q [NUM_CH];
  logic [NUM_CH-1:0] hold_range_q;
  logic [`ODS_CODE_W-1:0] out_code_q [NUM_CH];
  logic [NUM_CH-1:0] out_range_q;
  logic xfer_all;
  logic [NUM_CH*`ODS_CODE_W-1:0] hold_flat;

  // a software transfer behaves like an update_strobe low pulse
  assign xfer_all = upd_fall | soft_xfer;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic hit;
      logic [`ODS_CODE_W-1:0] hold_code_d;
      logic hold_range_d;

      assign hit = take && word_sel == ods_pkg::ods_sel_t'(g);
      assign hold_code_d = hit ? word_code : hold_code_q[g];
      assign hold_range_d = hit ? word_range : hold_range_q[g];

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          hold_code_q[g] <= `ODS_CODE_RST;
          hold_range_q[g] <= `ODS_RANGE_RST;
        end else if (soft_clear) begin
          hold_code_q[g] <= `ODS_CODE_RST;
          hold_range_q[g] <= `ODS_RANGE_RST;
        end else begin
          hold_code_q[g] <= hold_code_d;
          hold_range_q[g] <= hold_range_d;
        end
      end

      // a word taken with update_strobe low goes straight through
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          out_code_q[g] <= `ODS_CODE_RST;
          out_range_q[g] <= `ODS_RANGE_RST;
        end else if (soft_clear) begin
          out_code_q[g] <= `ODS_CODE_RST;
          out_range_q[g] <= `ODS_RANGE_RST;
        end else if (xfer_all || (hit && !upd_s)) begin
          out_code_q[g] <= hold_code_d;
          out_range_q[g] <= hold_range_d;
        end
      end

      // analog stage forms ref*code/256*(1+range) from these bits
      assign chan_code[g*`ODS_CODE_W +: `ODS_CODE_W] = out_code_q[g];
      assign chan_range[g] = out_range_q[g];
      assign hold_flat[g*`ODS_CODE_W +: `ODS_CODE_W] = hold_code_q[g];
    end
  endgenerate

  // read mux
  logic [31:0] rd_d;
  logic [31:0] rd_status;
  logic [31:0] rd_out;
  logic [31:0] rd_hold;

  assign rd_status = {6'h00, upd_s, latch_s, 3'h0, bits, 4'h0, word};
  assign rd_out = {23'h000000, out_range_q[reg_ch], out_code_q[reg_ch]};
  assign rd_hold = {23'h000000, hold_range_q[reg_ch], hold_code_q[reg_ch]};
  assign rd_d = is_status ? rd_status : is_out ? rd_out : is_hold ? rd_hold : 32'h00000000;

  // one wait state: answer the cycle after the request is seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= ods_pkg::ODS_BUS_IDLE;
      rdata_q <= 32'h00000000;
    end else begin
      unique case (bus_q)
        ods_pkg::ODS_BUS_IDLE: begin
          if (req) begin
            bus_q <= ods_pkg::ODS_BUS_ACK;
            rdata_q <= avs_read ? rd_d : 32'h00000000;
          end
        end
        ods_pkg::ODS_BUS_ACK: begin
          bus_q <= ods_pkg::ODS_BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = bus_q != ods_pkg::ODS_BUS_ACK;

  // helper for the power-up check
  logic touched_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      touched_q <= 1'b0;
    end else if (take || xfer_all) begin
      touched_q <= 1'b1;
    end
  end

  property p_power_zero;
    @(posedge clk) disable iff (!rst_b)
      !touched_q |-> (chan_code == '0 && chan_range == '0);
  endproperty
  a_power_zero: assert property (p_power_zero) else $error("outputs not at zero after power up");

  property p_take_hold;
    @(posedge clk) disable iff (!rst_b)
      (take && !soft_clear) |=> (hold_code_q[$past(word_sel)] == $past(word_code));
  endproperty
  a_take_hold: assert property (p_take_hold) else $error("word not latched into selected channel");

  property p_take_range;
    @(posedge clk) disable iff (!rst_b)
      (take && !soft_clear) |=> (hold_range_q[$past(word_sel)] == $past(word_range));
  endproperty
  a_take_range: assert property (p_take_range) else $error("range bit not latched");

  property p_direct;
    @(posedge clk) disable iff (!rst_b)
      (take && !upd_s && !soft_clear) |=>
        (chan_code[$past(word_sel)*8 +: 8] == $past(word_code) && chan_range[$past(word_sel)] == $past(word_range));
  endproperty
  a_direct: assert property (p_direct) else $error("direct update missed on latch fall");

  property p_deferred;
    @(posedge clk) disable iff (!rst_b)
      (take && upd_s && !soft_xfer && !soft_clear) |=> $stable(chan_code) && $stable(chan_range);
  endproperty
  a_deferred: assert property (p_deferred) else $error("output changed while update_strobe high");

  property p_xfer_all;
    @(posedge clk) disable iff (!rst_b)
      (upd_fall && !take && !soft_clear) |=> (chan_code == $past(hold_flat) && chan_range == $past(hold_range_q));
  endproperty
  a_xfer_all: assert property (p_xfer_all) else $error("update_strobe fall did not transfer held values");

  property p_sel_map;
    @(posedge clk) disable iff (!rst_b)
      (take && word_sel == 3'h7 && !soft_clear) |=> hold_code_q[7] == $past(word[7:0]);
  endproperty
  a_sel_map: assert property (p_sel_map) else $error("select 111 did not reach the eighth channel");

  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_ack;
    @(posedge clk) disable iff (!rst_b)
      ((avs_read || avs_write) && avs_waitrequest) |=> s_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle after request");

  sequence s_latch_fall;
    latch_s ##1 !latch_s;
  endsequence

  property p_take_edge;
    @(posedge clk) disable iff (!rst_b)
      s_latch_fall |-> take;
  endproperty
  a_take_edge: assert property (p_take_edge) else $error("latch_strobe fall did not take the word");

  sequence s_upd_fall;
    upd_s ##1 !upd_s;
  endsequence

  property p_upd_edge;
    @(posedge clk) disable iff (!rst_b)
      s_upd_fall |-> upd_fall;
  endproperty
  a_upd_edge: assert property (p_upd_edge) else $error("update_strobe fall not seen");

  property p_hold_still;
    @(posedge clk) disable iff (!rst_b)
      (!take && !soft_clear) |=> $stable(hold_flat) && $stable(hold_range_q);
  endproperty
  a_hold_still: assert property (p_hold_still) else $error("held value changed without a take");

  property p_out_still;
    @(posedge clk) disable iff (!rst_b)
      (!take && !xfer_all && !soft_clear) |=> $stable(chan_code) && $stable(chan_range);
  endproperty
  a_out_still: assert property (p_out_still) else $error("output changed without an update event");

  property p_soft_xfer;
    @(posedge clk) disable iff (!rst_b)
      (soft_xfer && !take && !soft_clear) |=> (chan_code == $past(hold_flat) && chan_range == $past(hold_range_q));
  endproperty
  a_soft_xfer: assert property (p_soft_xfer) else $error("control transfer did not copy held values");

  property p_clear;
    @(posedge clk) disable iff (!rst_b)
      soft_clear |=> (chan_code == '0 && chan_range == '0 && hold_flat == '0 && hold_range_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("soft clear left a channel nonzero");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_b)
      (avs_read && avs_waitrequest && !is_status && !is_out && !is_hold) |=> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");

  property p_write_rd;
    @(posedge clk) disable iff (!rst_b)
      (avs_write && avs_waitrequest) |=> avs_readdata == 32'h00000000;
  endproperty
  a_write_rd: assert property (p_write_rd) else $error("write answer carried read data");

  property p_wait_idle;
    @(posedge clk) disable iff (!rst_b)
      (!avs_read && !avs_write && avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("bus answered without a request");

  property p_bits_clear;
    @(posedge clk) disable iff (!rst_b)
      take |=> bits == '0;
  endproperty
  a_bits_clear: assert property (p_bits_clear) else $error("bit count not cleared by a take");

  property p_ch0_map;
    @(posedge clk) disable iff (!rst_b)
      (take && word_sel == 3'h0 && !soft_clear) |=> hold_code_q[0] == $past(word_code);
  endproperty
  a_ch0_map: assert property (p_ch0_map) else $error("select 000 did not reach the first channel");

  property p_zero_ground;
    @(posedge clk) disable iff (!rst_b)
      (take && !upd_s && !soft_clear && word_code == 8'h00) |=> chan_code[$past(word_sel)*8 +: 8] == 8'h00;
  endproperty
  a_zero_ground: assert property (p_zero_ground) else $error("zero code did not drive ground");

  property p_status_pins;
    @(posedge clk) disable iff (!rst_b)
      (avs_read && avs_waitrequest && is_status) |=> avs_readdata[25:24] == {$past(upd_s), $past(latch_s)};
  endproperty
  a_status_pins: assert property (p_status_pins) else $error("status strobe bits wrong");
endmodule // ods_top
`default_nettype wire

//--- ods_host.sv
`timescale 1ns/1ps
`default_nettype none
module ods_host (
  input wire logic clk,
  output var logic serial_clk,
  output var logic serial_data,
  output var logic latch_strobe,
  output var logic update_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b1;
    update_strobe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // low n bits of w, msb first, 800 ns per bit, latch high throughout
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= w[i];
      serial_clk <= 1'b1;
      hold(4);
      serial_clk <= 1'b0;
      hold(4);
    end
    // released line shows the inverse, never a stale bit
    serial_data <= ~w[0];
  endtask
  // 400 ns low pulse takes the word
  task automatic take();
    latch_strobe <= 1'b0;
    hold(4);
    latch_strobe <= 1'b1;
    hold(8);
  endtask
  // high holds new values, high to low transfers them
  task automatic set_upd(input logic v);
    update_strobe <= v;
    hold(8);
  endtask
endmodule // ods_host
`default_nettype wire

//--- octal_dac_serial_update_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module octal_dac_serial_update_ctrl_tb;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, chan_range;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [63:0] chan_code;
  wire sclk, sdat, latch, upd;
  int n_errors = 0;
  int tests_run = 0;
  int upd_m = 0;
  int oc[8], orng[8], hc[8], hr[8];
  ods_host host (.clk(clk), .serial_clk(sclk), .serial_data(sdat), .latch_strobe(latch), .update_strobe(upd));
  ods_top dut (
    .clk(clk), .rst_b(rst_b), .serial_clk(sclk), .serial_data(sdat), .latch_strobe(latch),
    .update_strobe(upd), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chan_code(chan_code), .chan_range(chan_range)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // request stands until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) chk(1, 0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic check_all();
    repeat (8) @(posedge clk);
    for (int n = 0; n < 8; n++) begin
      chk(chan_code[8*n+:8], oc[n]);
      chk(chan_range[n], orng[n]);
      bus(1'b0, 8'(32 + 4 * n), 0);
      chk(rd, orng[n] * 256 + oc[n]);
      bus(1'b0, 8'(64 + 4 * n), 0);
      chk(rd, hr[n] * 256 + hc[n]);
    end
  endtask
  // split sends 16 bits as two bursts with junk ahead; only the last 12 count
  task automatic send(input int ch, input int c, input int r, input bit split);
    logic [15:0] w;
    w = 16'($urandom_range(15) * 4096 + ch * 512 + r * 256 + c);
    if (split) begin
      host.shift(w >> 8, 8);
      host.hold(8);
      host.shift(w, 8);
    end else host.shift(w, 12);
    host.take();
    hc[ch] = c;
    hr[ch] = r;
    if (upd_m == 0) begin
      oc[ch] = c;
      orng[ch] = r;
    end
  endtask
  task automatic fill(input bit split);
    for (int n = 0; n < 8; n++) send(n, n == 0 ? 255 : n == 7 ? 0 : $urandom_range(255), $urandom_range(1), split);
  endtask
  initial begin
    #3_000_000;
    n_errors++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    void'($urandom(84011));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check_all();
    fill(1'b0);
    check_all();
    bus(1'b0, 8'h04, 0);
    chk(rd[25:24], 2'b01);
    chk(rd[20:0], 7 * 512 + hr[7] * 256 + hc[7]);
    bus(1'b0, 8'h10, 0);
    chk(rd, 0); // unmapped reads zero
    host.set_upd(1'b1);
    upd_m = 1;
    fill(1'b1);
    check_all();
    host.set_upd(1'b0);
    upd_m = 0;
    oc = hc;
    orng = hr;
    check_all();
    host.set_upd(1'b1);
    upd_m = 1;
    send(3, $urandom_range(255), 1, 1'b0);
    check_all();
    bus(1'b1, 8'h00, 1);
    oc = hc;
    orng = hr;
    check_all(); // transfer through control word
    bus(1'b1, 8'h00, 2);
    oc = '{default: 0};
    orng = '{default: 0};
    hc = '{default: 0};
    hr = '{default: 0};
    check_all(); // soft clear back to ground
    test_done();
  end
endmodule // octal_dac_serial_update_ctrl_tb
`default_nettype wire
